// file: shared/fpu_consts.svh
// Bit positions, reset values, opcodes and exponent limits of the floating unit.
`ifndef FPU_CONSTS_SVH
`define FPU_CONSTS_SVH

`define FS_ERR       15
`define FS_GDIS      14
`define FS_UV_EN     11
`define FS_UNF_EN    10
`define FS_OVF_EN    9
`define FS_CNV_EN    8
`define FS_DBL       7
`define FS_LONG      6
`define FS_CHOP      5
`define FS_N         3
`define FS_Z         2
`define FS_V         1
`define FS_C         0
`define FS_WR_MASK   16'hcfef
`define FS_RESET     16'h0000

`define ACC_RESET    64'h0000_0000_0000_0000
`define ACC_LAST     3'h5
`define NUM_ACC      6

`define EXP_BIAS     12'sh080
`define EXP_MAX      12'sh0ff
`define EXP_MIN      12'sh001
`define I2F_EXP_BASE 12'sh0a0
`define TE_MAX_LONG  12'sh01f
`define TE_MAX_SHORT 12'sh00f

`define OP_LOAD      4'h0
`define OP_STORE     4'h1
`define OP_NEG       4'h2
`define OP_ABS       4'h3
`define OP_TST       4'h4
`define OP_CMP       4'h5
`define OP_MUL       4'h6
`define OP_DIV       4'h7
`define OP_F2I       4'h8
`define OP_I2F       4'h9

`endif

// file: shared/fpu_pkg.sv
// Types shared by the floating unit and its surroundings.
package fpu_pkg;

	typedef enum logic [2:0] {
		EXC_NONE,
		EXC_UNDEF,
		EXC_OVF,
		EXC_UNF,
		EXC_CONV,
		EXC_DIV0,
		EXC_ILLEGAL
	} fp_exc_e;

	typedef struct packed {
		logic [3:0]  opcode;
		logic [2:0]  ac;
		logic        from_mem;
		logic [63:0] operand;
	} fp_req_s;

	typedef struct packed {
		logic        sign;
		logic [7:0]  exp;
		logic [55:0] frac;
	} fp_unpk_s;

endpackage

// file: rtl/float_format_status_unit.sv
// Floating unit: formats, accumulators, status register and exception handling.
`timescale 1ns/10ps
`include "fpu_consts.svh"

// How it works
// RULE1: Single operands are 32-bit words, double 64-bit, both sign-magnitude.
// RULE2: Store 23 or 55 fraction bits, restore hidden one before arithmetic.
// RULE3: Exponent is eight bits biased by 128; valid biased values 1 to 255.
// RULE4: Biased exponent zero means zero; such operands trap or act as exact zero.
// RULE5: Clean zero is all zero bits; dirty zero has zero exponent, nonzero fraction.
// RULE6: Flag overflow above the exponent limit, underflow below -127, fraction kept correct.
// RULE7: Sign set with exponent zero is the undefined variable without arithmetic value.
// RULE8: Overflow or underflow with its interrupt disabled stores an exact zero.
// RULE9: Convert float and two's-complement integers, 16 or 32 bits by mode.
// RULE10: Six 64-bit accumulators hold single and double operands.
// RULE11: Mode bits choose precision, integer length and chop or round.
// RULE12: Each instruction updates error flag and carry, overflow, zero, negative codes.
// RULE13: Detect undefined fetch, overflow, underflow, conversion, divide by zero, illegal opcode.
// RULE14: First four exceptions have own enables; last two only globally disabled.
// RULE15: Error flag sets on divide by zero, illegal opcode, or enabled exception.
// RULE16: Unit never clears the error flag; only a status load does.
// RULE17: Global disable bit suppresses every floating exception interrupt.
// RULE18: Software keeps the global disable clear so every stored minus zero traps; the unit traps only with FS_UV_EN set and a memory fetch.
// RULE19: Status load writes all mode and interrupt control bits.
// RULE20: Minus zero fetched from memory traps before execution when enabled, never from registers.
// RULE21: Single mode uses the upper accumulator half; the lower half is untouched.
module float_format_status_unit (
	// Clock, reset and enable
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_b,
	input  wire logic             i_ce,
	// Status load from the sequencer
	input  wire logic             i_stat_load,
	input  wire logic [15:0]      i_stat_data,
	// Instruction request
	input  wire logic             i_req_valid,
	input  wire fpu_pkg::fp_req_s i_req,
	// Results and status
	output logic                  o_done,
	output logic [63:0]           o_result,
	output logic [15:0]           o_status,
	output logic                  o_trap,
	output fpu_pkg::fp_exc_e      o_trap_code
);

	// Splits a stored word, restoring the hidden bit unless the exponent is zero.
	function automatic fpu_pkg::fp_unpk_s unpack(input logic [63:0] w, input logic d);
		fpu_pkg::fp_unpk_s u;
		u.sign = w[63];
		u.exp  = w[62:55];
		u.frac = (w[62:55] == 8'h00) ? 56'h0 : {1'b1, w[54:32], (d ? w[31:0] : 32'h0)}; // [RULE2] [RULE4]
		return u;
	endfunction

	function automatic logic [63:0] pack(input logic s, input logic [7:0] e,
		input logic [55:0] f, input logic d);
		return {s, e, f[54:32], (d ? f[31:0] : 32'h0)}; // [RULE1] [RULE3]
	endfunction

	function automatic logic is_undef(input logic [63:0] w);
		return w[63] && (w[62:55] == 8'h00); // [RULE7]
	endfunction

	function automatic logic uses_mem(input logic [3:0] op);
		return (op == `OP_LOAD) || (op == `OP_NEG) || (op == `OP_ABS) || (op == `OP_TST) ||
			(op == `OP_CMP) || (op == `OP_MUL) || (op == `OP_DIV);
	endfunction

	// Chops or rounds a 56-bit fraction plus guard bit to the precision in use.
	function automatic logic [67:0] round_fix(input logic [56:0] m, input logic signed [11:0] e,
		input logic d, input logic chop);
		logic [57:0]        s;
		logic signed [11:0] en;
		logic [55:0]        f;
		s  = {1'b0, m} + (chop ? 58'h0 : (d ? 58'h1 : 58'h1_0000_0000)); // [RULE11]
		en = e;
		f  = s[56:1];
		if (s[57])
		begin
			f  = s[57:2];
			en = e + 12'sh001;
		end
		if (!d)
			f[31:0] = 32'h0;
		return {en, f};
	endfunction

	function automatic logic [5:0] clz32(input logic [31:0] v);
		logic [5:0] n;
		logic       found;
		n     = 6'h00;
		found = 1'b0;
		for (int i = 31; i >= 0; i--)
		begin
			if (!found && v[i])
				found = 1'b1;
			else if (!found)
				n = n + 6'h01;
		end
		return n;
	endfunction

	logic [15:0]          float_status_control;
	logic [15:0]          next_fsc;
	logic [63:0]          acc [`NUM_ACC];
	fpu_pkg::fp_unpk_s    ua;
	fpu_pkg::fp_unpk_s    ub;
	logic [63:0]          res_word;
	logic [3:0]           res_cc;
	logic                 writes_acc;
	logic                 known;
	fpu_pkg::fp_exc_e     exc_code;

	wire logic            taken    = i_ce && i_req_valid;
	wire logic            dbl      = float_status_control[`FS_DBL];
	wire logic            long_int = float_status_control[`FS_LONG];
	wire logic            chop     = float_status_control[`FS_CHOP];
	wire logic            ovf_en   = float_status_control[`FS_OVF_EN];
	wire logic            unf_en   = float_status_control[`FS_UNF_EN];
	wire logic            cnv_en   = float_status_control[`FS_CNV_EN];
	wire logic [3:0]      op       = i_req.opcode;
	wire logic [2:0]      ac       = i_req.ac;
	wire logic            ac_ok    = (ac <= `ACC_LAST);
	wire logic [63:0]     acc_raw  = ac_ok ? acc[ac] : `ACC_RESET;
	wire logic [63:0]     acc_w    = dbl ? acc_raw : {acc_raw[63:32], 32'h0}; // [RULE21]
	wire logic [63:0]     src_w    = dbl ? i_req.operand : {i_req.operand[63:32], 32'h0};

	assign ua = unpack(acc_w, dbl);
	assign ub = unpack(src_w, dbl);

	// Multiply: the product of two normalised fractions lies in [1/4, 1).
	wire logic [111:0]        prod  = ua.frac * ub.frac;
	wire logic [56:0]         mul_m = prod[111] ? prod[111:55] : prod[110:54];
	wire logic signed [11:0]  mul_e = $signed({4'h0, ua.exp}) + $signed({4'h0, ub.exp}) -
		`EXP_BIAS - (prod[111] ? 12'sh000 : 12'sh001);

	// Divide: the quotient of two normalised fractions lies in (1/2, 2).
	wire logic [112:0]        quo   = {ua.frac, 57'h0} / {57'h0, ub.frac};
	wire logic [56:0]         div_m = quo[57] ? quo[57:1] : quo[56:0];
	wire logic signed [11:0]  div_e = $signed({4'h0, ua.exp}) - $signed({4'h0, ub.exp}) +
		`EXP_BIAS + (quo[57] ? 12'sh001 : 12'sh000);

	// Integer to float, exact before rounding to the selected precision.
	wire logic [31:0]         isrc  = long_int ? i_req.operand[31:0] :
		{{16{i_req.operand[15]}}, i_req.operand[15:0]}; // [RULE9]
	wire logic [31:0]         imag  = isrc[31] ? (32'h0 - isrc) : isrc;
	wire logic [5:0]          lz    = clz32(imag);
	wire logic [31:0]         inorm = imag << lz;
	wire logic signed [11:0]  i2f_e = `I2F_EXP_BASE - $signed({6'h00, lz});

	wire logic                is_mul   = (op == `OP_MUL);
	wire logic                is_div   = (op == `OP_DIV);
	wire logic                is_i2f   = (op == `OP_I2F);
	wire logic                is_arith = is_mul || is_div || is_i2f;
	wire logic [56:0]         arith_m  = is_i2f ? {inorm, 25'h0} : (is_div ? div_m : mul_m);
	wire logic signed [11:0]  arith_e  = is_i2f ? i2f_e : (is_div ? div_e : mul_e);
	wire logic                arith_s  = is_i2f ? isrc[31] : (ua.sign ^ ub.sign);
	wire logic                arith_z  = is_i2f ? (imag == 32'h0) :
		((ua.exp == 8'h00) || (is_mul && (ub.exp == 8'h00))); // [RULE4]
	wire logic [67:0]         rnd      = round_fix(arith_m, arith_e, dbl, chop);
	wire logic signed [11:0]  ae       = rnd[67:56];
	wire logic                ovf_x    = is_arith && !arith_z && (ae > `EXP_MAX); // [RULE6]
	wire logic                unf_x    = is_arith && !arith_z && (ae < `EXP_MIN); // [RULE6]
	wire logic                clean0   = arith_z || (ovf_x && !ovf_en) || (unf_x && !unf_en);
	// Exponent bits wrap while the fraction stays correct for enabled traps.
	wire logic [63:0]         ar_word  = clean0 ? 64'h0 :
		pack(arith_s, ae[7:0], rnd[55:0], dbl); // [RULE5] [RULE8]

	// Float to integer, truncating toward zero.
	wire logic signed [11:0]  te       = $signed({4'h0, ua.exp}) - `EXP_BIAS;
	wire logic signed [11:0]  te_max   = long_int ? `TE_MAX_LONG : `TE_MAX_SHORT;
	wire logic                cnv_x    = (op == `OP_F2I) && (ua.exp != 8'h00) && (te > te_max);
	wire logic [5:0]          sh       = 6'h20 - te[5:0];
	wire logic [31:0]         fmag     = ((ua.exp == 8'h00) || (te < 12'sh001)) ? 32'h0 :
		(ua.frac[55:24] >> sh);
	wire logic [31:0]         ival     = ua.sign ? (32'h0 - fmag) : fmag;
	wire logic [63:0]         f2i_word = cnv_x ? 64'h0 :
		(long_int ? {32'h0, ival} : {48'h0, ival[15:0]}); // [RULE9]

	// Compare source against accumulator with exponent-zero values as zero.
	wire logic                sa   = (ua.exp != 8'h00) && ua.sign;
	wire logic                sb   = (ub.exp != 8'h00) && ub.sign;
	wire logic [63:0]         ka   = {ua.exp, ua.frac};
	wire logic [63:0]         kb   = {ub.exp, ub.frac};
	wire logic                c_eq = (ka == kb) && (sa == sb);
	wire logic                c_lt = (sa != sb) ? sb : (sb ? (kb > ka) : (kb < ka));

	always_comb
	begin
		res_word   = 64'h0;
		res_cc     = float_status_control[3:0];
		writes_acc = 1'b0;
		known      = 1'b1;
		case (op)
			`OP_LOAD:
			begin
				res_word   = src_w;
				writes_acc = 1'b1;
				res_cc     = {src_w[63], ub.exp == 8'h00, 2'b00};
			end
			`OP_STORE:
			begin
				res_word = acc_w;
				res_cc   = {acc_w[63], ua.exp == 8'h00, 2'b00};
			end
			`OP_NEG, `OP_ABS:
			begin
				res_word   = (ub.exp == 8'h00) ? 64'h0 :
					{(op == `OP_NEG) ? ~src_w[63] : 1'b0, src_w[62:0]};
				writes_acc = 1'b1;
				res_cc     = {res_word[63], ub.exp == 8'h00, 2'b00};
			end
			`OP_TST:
			begin
				res_word = src_w;
				res_cc   = {sb, ub.exp == 8'h00, 2'b00};
			end
			`OP_CMP:
				res_cc = {c_lt, c_eq, 2'b00};
			`OP_MUL, `OP_DIV, `OP_I2F:
			begin
				res_word   = ar_word;
				writes_acc = 1'b1;
				res_cc     = {ar_word[63], ar_word[62:55] == 8'h00, ovf_x || unf_x, 1'b0}; // [RULE12]
			end
			`OP_F2I:
				res_cc = {ival[31] && !cnv_x, f2i_word == 64'h0, 1'b0, cnv_x}; // [RULE12]
			default:
				known = 1'b0;
		endcase
	end

	// Exceptions, highest priority first; the first three abort before execution.
	wire logic illegal_x = !known || !ac_ok; // [RULE13]
	wire logic undef_x   = uses_mem(op) && i_req.from_mem && is_undef(i_req.operand) &&
		float_status_control[`FS_UV_EN]; // [RULE20]
	wire logic div0_x    = is_div && (ub.exp == 8'h00); // [RULE13]
	wire logic abort     = illegal_x || undef_x || div0_x;
	wire logic exc_en    = abort || (ovf_x && ovf_en) || (unf_x && unf_en) ||
		(cnv_x && cnv_en); // [RULE14]
	wire logic trap_now  = exc_en && !float_status_control[`FS_GDIS]; // [RULE17]
	wire logic acc_we    = taken && !abort && writes_acc;
	wire logic [63:0] acc_wdata = dbl ? res_word : {res_word[63:32], acc_raw[31:0]}; // [RULE21]

	assign exc_code = illegal_x ? fpu_pkg::EXC_ILLEGAL :
		undef_x ? fpu_pkg::EXC_UNDEF :
		div0_x  ? fpu_pkg::EXC_DIV0 :
		ovf_x   ? fpu_pkg::EXC_OVF :
		unf_x   ? fpu_pkg::EXC_UNF :
		cnv_x   ? fpu_pkg::EXC_CONV : fpu_pkg::EXC_NONE;

	// A load in the same cycle as an error still leaves the error flag set.
	always_comb
	begin
		next_fsc = i_stat_load ? (i_stat_data & `FS_WR_MASK) : float_status_control; // [RULE19]
		if (taken && !abort)
			next_fsc[3:0] = res_cc; // [RULE12]
		if (taken && exc_en)
			next_fsc[`FS_ERR] = 1'b1; // [RULE15] [RULE16]
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			float_status_control <= `FS_RESET;
		else if (i_ce)
			float_status_control <= next_fsc;
	end

	for (genvar g = 0; g < `NUM_ACC; g++)
	begin : g_acc
		always_ff @(posedge i_core_clk or negedge i_rst_b)
		begin
			if (!i_rst_b)
				acc[g] <= `ACC_RESET;
			else if (acc_we && (ac == 3'(g)))
				acc[g] <= acc_wdata; // [RULE10]
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_done      <= 1'b0;
			o_result    <= 64'h0;
			o_trap      <= 1'b0;
			o_trap_code <= fpu_pkg::EXC_NONE;
		end
		else if (i_ce)
		begin
			o_done      <= i_req_valid;
			o_trap      <= i_req_valid && trap_now; // [RULE17]
			o_trap_code <= (i_req_valid && exc_en) ? exc_code : fpu_pkg::EXC_NONE;
			if (i_req_valid)
				o_result <= abort ? 64'h0 : ((op == `OP_F2I) ? f2i_word : res_word);
		end
	end

	assign o_status = float_status_control;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_b);

	a_err_sticky: assert property ( // [RULE16]
		float_status_control[`FS_ERR] && !(i_ce && i_stat_load) |=> float_status_control[`FS_ERR])
		else $error("error flag cleared without a status load");
	a_gdis_quiet: assert property ( // [RULE17]
		taken && float_status_control[`FS_GDIS] |=> !o_trap)
		else $error("trap raised while globally disabled");
	a_div0_err: assert property ( // [RULE15]
		taken && is_div && known && ac_ok && !undef_x && (ub.exp == 8'h00)
		|=> float_status_control[`FS_ERR] && (o_trap_code == fpu_pkg::EXC_DIV0))
		else $error("divide by zero not flagged");
	a_undef_trap: assert property ( // [RULE20]
		taken && (op == `OP_LOAD) && ac_ok && i_req.from_mem && is_undef(i_req.operand) &&
		float_status_control[`FS_UV_EN] && !float_status_control[`FS_GDIS]
		|=> o_trap && (o_trap_code == fpu_pkg::EXC_UNDEF))
		else $error("minus zero fetch did not trap");
	a_undef_reg: assert property ( // [RULE20]
		taken && !i_req.from_mem |=> o_trap_code != fpu_pkg::EXC_UNDEF)
		else $error("register operand raised undefined trap");
	a_ovf_zero: assert property ( // [RULE8]
		taken && known && ac_ok && !undef_x && (ovf_x && !ovf_en || unf_x && !unf_en)
		|=> o_result == 64'h0)
		else $error("disabled overflow did not store clean zero");
	a_no_minus0: assert property ( // [RULE7]
		taken && is_arith && ac_ok && !undef_x && !ovf_en && !unf_en |=> !is_undef(o_result))
		else $error("arithmetic produced the undefined variable");
	a_illegal_err: assert property ( // [RULE14]
		taken && illegal_x
		|=> float_status_control[`FS_ERR] && (o_trap == !$past(float_status_control[`FS_GDIS])))
		else $error("illegal opcode not flagged");
	a_stat_load: assert property ( // [RULE19]
		i_ce && i_stat_load && !i_req_valid |=> o_status == ($past(i_stat_data) & `FS_WR_MASK))
		else $error("status load value not taken");
	a_conv_carry: assert property ( // [RULE12]
		taken && cnv_x && ac_ok |=> o_status[`FS_C] && (o_result == 64'h0))
		else $error("conversion failure not reported");
	a_single_low: assert property ( // [RULE21]
		acc_we && !dbl |=> acc[$past(ac)][31:0] == $past(acc_raw[31:0]))
		else $error("single write disturbed lower half");

	c_div0: cover property (taken && div0_x ##1 o_trap);
	c_undef: cover property (taken && undef_x ##1 o_trap);
	c_ovf_wrap: cover property (taken && ovf_x && ovf_en ##1 o_done);
	c_load_err: cover property (i_ce && i_stat_load && taken && exc_en);

endmodule

// file: dv/fpu_sequencer_model.sv
// Instruction sequencer model that feeds status loads and floating requests to the unit.
`timescale 1ns/10ps
module fpu_sequencer_model (
	// Clock
	input  wire logic             i_core_clk,
	// Requests towards the unit
	output logic                  o_stat_load,
	output logic [15:0]           o_stat_data,
	output logic                  o_req_valid,
	output fpu_pkg::fp_req_s      o_req
);
	initial
	begin
		o_stat_load = 1'b0;
		o_stat_data = 16'h0000;
		o_req_valid = 1'b0;
		o_req       = '0;
	end

	// The global disable stays clear unless the caller asks for it on purpose.
	task automatic load_status(input logic [15:0] d);
		@(posedge i_core_clk);
		#1;
		o_stat_load = 1'b1;
		o_stat_data = d;
		@(posedge i_core_clk);
		#1;
		o_stat_load = 1'b0;
		o_stat_data = ~d;
	endtask

	// Released operand lines show the inverse so stale data is never mistaken for valid.
	task automatic issue(input logic [3:0] op, input logic [2:0] ac, input logic mem,
		input logic [63:0] val);
		@(posedge i_core_clk);
		#1;
		o_req_valid = 1'b1;
		o_req       = '{opcode: op, ac: ac, from_mem: mem, operand: val};
		@(posedge i_core_clk);
		#1;
		o_req_valid   = 1'b0;
		o_req.operand = ~val;
	endtask
endmodule

// file: dv/test_float_format_status_unit.sv
// Self-checking testbench for the floating format and status unit.
`timescale 1ns/10ps
`include "fpu_consts.svh"
module test_float_format_status_unit;
	logic             i_core_clk;
	logic             i_rst_b;
	logic             i_ce;
	logic             i_stat_load;
	logic [15:0]      i_stat_data;
	logic             i_req_valid;
	fpu_pkg::fp_req_s i_req;
	logic             o_done;
	logic [63:0]      o_result;
	logic [15:0]      o_status;
	logic             o_trap;
	fpu_pkg::fp_exc_e o_trap_code;
	int               n_fail;
	int               total_checks;

	localparam logic [63:0] ONE_D = 64'h4080_0000_0000_0000;
	localparam logic [63:0] MZERO = 64'h8000_0000_0000_0000;
	localparam logic [63:0] BIG   = 64'h7f80_0000_0000_0000;
	localparam logic [63:0] TINY  = 64'h0080_0000_0000_0000;

	float_format_status_unit dut (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.i_ce       (i_ce),
		.i_stat_load(i_stat_load),
		.i_stat_data(i_stat_data),
		.i_req_valid(i_req_valid),
		.i_req      (i_req),
		.o_done     (o_done),
		.o_result   (o_result),
		.o_status   (o_status),
		.o_trap     (o_trap),
		.o_trap_code(o_trap_code)
	);

	fpu_sequencer_model seq (
		.i_core_clk (i_core_clk),
		.o_stat_load(i_stat_load),
		.o_stat_data(i_stat_data),
		.o_req_valid(i_req_valid),
		.o_req      (i_req)
	);

	always #25 i_core_clk = ~i_core_clk;

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// Compares the done pulse, the interrupt request and its code together.
	task automatic tchk(input logic t, input fpu_pkg::fp_exc_e c);
		chk({59'h0, o_done, o_trap, 3'(o_trap_code)}, {59'h0, 1'b1, t, 3'(c)});
	endtask

	task automatic test_done;
		$display("checks=%0d mismatches=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic t_status;
		chk(64'(o_status), 64'h0);
		seq.load_status(16'hffff);
		chk(64'(o_status), 64'h0000_0000_0000_cfef);
		seq.load_status(16'h0000);
		chk(64'(o_status), 64'h0);
		$display("test status done");
	endtask

	task automatic t_formats;
		seq.load_status(16'h0080);
		seq.issue(`OP_LOAD, 3'h1, 1'b1, 64'h4080_0000_1234_5678);
		chk(o_result, 64'h4080_0000_1234_5678);
		chk(64'(o_status[3:0]), 64'h0);
		seq.load_status(16'h0000);
		seq.issue(`OP_LOAD, 3'h1, 1'b1, 64'hc100_0000_aaaa_aaaa);
		chk(64'(o_status[3:0]), 64'h8);
		seq.load_status(16'h0080);
		seq.issue(`OP_STORE, 3'h1, 1'b0, 64'h0);
		chk(o_result, 64'hc100_0000_1234_5678);
		seq.issue(`OP_LOAD, 3'h0, 1'b1, 64'h0);
		chk(64'(o_status[3:0]), 64'h4);
		for (int a = 0; a < 6; a++)
			seq.issue(`OP_LOAD, 3'(a), 1'b1, {8'h40, 8'(a + 1), 48'h0});
		for (int a = 0; a < 6; a++)
		begin
			seq.issue(`OP_STORE, 3'(a), 1'b0, 64'h0);
			chk(o_result, {8'h40, 8'(a + 1), 48'h0});
		end
		seq.issue(`OP_STORE, 3'h6, 1'b0, 64'h0);
		tchk(1'b1, fpu_pkg::EXC_ILLEGAL);
		$display("test formats done");
	endtask

	task automatic t_undef;
		seq.load_status(16'h0880);
		seq.issue(`OP_LOAD, 3'h0, 1'b1, MZERO | 64'h0000_0001_0000_0000);
		tchk(1'b1, fpu_pkg::EXC_UNDEF);
		chk(o_result, 64'h0);
		chk(64'(o_status[15]), 64'h1);
		seq.issue(`OP_LOAD, 3'h0, 1'b0, MZERO);
		tchk(1'b0, fpu_pkg::EXC_NONE);
		chk(64'(o_status[15]), 64'h1);
		seq.load_status(16'h4880);
		chk(64'(o_status[15]), 64'h0);
		seq.issue(`OP_LOAD, 3'h0, 1'b1, MZERO);
		chk({63'h0, o_trap}, 64'h0);
		chk(64'(o_status[15]), 64'h1);
		seq.load_status(16'h0080);
		seq.issue(`OP_LOAD, 3'h0, 1'b1, MZERO);
		tchk(1'b0, fpu_pkg::EXC_NONE);
		chk(64'(o_status[15]), 64'h0);
		$display("test undefined done");
	endtask

	task automatic t_div_illegal;
		seq.issue(`OP_LOAD, 3'h0, 1'b1, ONE_D);
		seq.issue(`OP_DIV, 3'h0, 1'b1, 64'h0);
		tchk(1'b1, fpu_pkg::EXC_DIV0);
		chk(64'(o_status[15]), 64'h1);
		seq.issue(`OP_STORE, 3'h0, 1'b0, 64'h0);
		chk(o_result, ONE_D);
		for (int op = 10; op < 16; op++)
		begin
			seq.issue(4'(op), 3'h0, 1'b0, ONE_D);
			tchk(1'b1, fpu_pkg::EXC_ILLEGAL);
		end
		seq.load_status(16'h4080);
		seq.issue(`OP_DIV, 3'h0, 1'b0, 64'h0);
		chk({63'h0, o_trap}, 64'h0);
		chk(64'(o_status[15]), 64'h1);
		$display("test divide and illegal done");
	endtask

	task automatic t_range;
		seq.load_status(16'h0080);
		seq.issue(`OP_LOAD, 3'h2, 1'b1, BIG);
		seq.issue(`OP_MUL, 3'h2, 1'b1, BIG);
		tchk(1'b0, fpu_pkg::EXC_NONE);
		chk({62'h0, o_status[15], o_status[1]}, 64'h1);
		seq.issue(`OP_STORE, 3'h2, 1'b0, 64'h0);
		chk(o_result, 64'h0);
		seq.load_status(16'h0280);
		seq.issue(`OP_LOAD, 3'h2, 1'b1, BIG);
		seq.issue(`OP_MUL, 3'h2, 1'b1, BIG);
		tchk(1'b1, fpu_pkg::EXC_OVF);
		chk(64'(o_status[15]), 64'h1);
		seq.issue(`OP_STORE, 3'h2, 1'b0, 64'h0);
		chk(o_result, 64'h3e80_0000_0000_0000);
		seq.load_status(16'h0480);
		seq.issue(`OP_LOAD, 3'h2, 1'b1, TINY);
		seq.issue(`OP_MUL, 3'h2, 1'b1, TINY);
		tchk(1'b1, fpu_pkg::EXC_UNF);
		$display("test range done");
	endtask

	task automatic t_convert;
		seq.load_status(16'h0080);
		seq.issue(`OP_LOAD, 3'h3, 1'b1, ONE_D);
		seq.issue(`OP_F2I, 3'h3, 1'b0, 64'h0);
		chk(o_result, 64'h1);
		seq.issue(`OP_I2F, 3'h3, 1'b1, 64'h0000_0000_0000_ffff);
		seq.issue(`OP_STORE, 3'h3, 1'b0, 64'h0);
		chk(o_result, 64'hc080_0000_0000_0000);
		seq.load_status(16'h00c0);
		seq.issue(`OP_I2F, 3'h3, 1'b1, 64'h0000_0000_0001_0000);
		seq.issue(`OP_STORE, 3'h3, 1'b0, 64'h0);
		chk(o_result, 64'h4880_0000_0000_0000);
		seq.load_status(16'h0040);
		seq.issue(`OP_I2F, 3'h3, 1'b1, 64'h0000_0000_0100_0001);
		seq.issue(`OP_STORE, 3'h3, 1'b0, 64'h0);
		chk(o_result, 64'h4c80_0001_0000_0000);
		seq.load_status(16'h0060);
		seq.issue(`OP_I2F, 3'h3, 1'b1, 64'h0000_0000_0100_0001);
		seq.issue(`OP_STORE, 3'h3, 1'b0, 64'h0);
		chk(o_result, 64'h4c80_0000_0000_0000);
		seq.load_status(16'h0180);
		seq.issue(`OP_F2I, 3'h3, 1'b0, 64'h0);
		tchk(1'b1, fpu_pkg::EXC_CONV);
		chk(o_result, 64'h0);
		chk({62'h0, o_status[15], o_status[0]}, 64'h3);
		$display("test convert done");
	endtask

	task automatic t_ops;
		seq.load_status(16'h0080);
		seq.issue(`OP_LOAD, 3'h4, 1'b1, ONE_D);
		seq.issue(`OP_NEG, 3'h4, 1'b1, ONE_D);
		chk(o_result, 64'hc080_0000_0000_0000);
		chk(64'(o_status[3:0]), 64'h8);
		seq.issue(`OP_ABS, 3'h4, 1'b1, 64'hc080_0000_0000_0000);
		chk(o_result, ONE_D);
		seq.issue(`OP_CMP, 3'h4, 1'b1, 64'hc080_0000_0000_0000);
		chk(64'(o_status[3:0]), 64'h8);
		seq.issue(`OP_CMP, 3'h4, 1'b1, ONE_D);
		chk(64'(o_status[3:0]), 64'h4);
		seq.issue(`OP_NEG, 3'h4, 1'b1, 64'h0000_0000_0000_0001);
		chk(o_result, 64'h0);
		seq.issue(`OP_TST, 3'h4, 1'b1, MZERO);
		chk(64'(o_status[3:0]), 64'h4);
		$display("test operations done");
	endtask

	// Freezes the unit with the clock enable, then resets it in mid-run.
	task automatic t_freeze;
		@(posedge i_core_clk);
		#1;
		i_ce = 1'b0;
		seq.issue(`OP_LOAD, 3'h5, 1'b1, ONE_D);
		seq.load_status(16'hffff);
		chk({63'h0, o_done}, 64'h0);
		chk(o_result, 64'h0);
		chk(64'(o_status), 64'h8185);
		i_ce = 1'b1;
		seq.issue(`OP_STORE, 3'h5, 1'b0, 64'h0);
		chk(o_result, {8'h40, 8'h06, 48'h0});
		@(posedge i_core_clk);
		#1;
		i_rst_b = 1'b0;
		@(posedge i_core_clk);
		#1;
		i_rst_b = 1'b1;
		chk({62'h0, o_done, o_trap}, 64'h0);
		chk(64'(o_status), 64'h0);
		seq.issue(`OP_STORE, 3'h5, 1'b0, 64'h0);
		tchk(1'b0, fpu_pkg::EXC_NONE);
		chk(o_result, 64'h0);
		$display("test freeze and reset done");
	endtask

	initial
	begin
		i_core_clk   = 1'b0;
		i_rst_b      = 1'b0;
		i_ce         = 1'b1;
		n_fail       = 0;
		total_checks = 0;
		repeat (6) @(posedge i_core_clk);
		#1;
		i_rst_b = 1'b1;
		t_status();
		t_formats();
		t_ops();
		t_undef();
		t_div_illegal();
		t_range();
		t_convert();
		t_freeze();
		test_done();
	end

	// Cuts a hung run short and reports it as a mismatch.
	initial
	begin
		repeat (20000) @(posedge i_core_clk);
		n_fail++;
		test_done();
	end
endmodule
